//--- hw/kli_pkg.sv
// constants for the keypad level interrupt block
// Function
// R1: flag of each line sets whenever its port line is at its active level
// R2: any read of the flag register clears all flags
// R3: enable bit zero leaves pin as plain I/O with no keypad request
// R4: enable bit one lets that line's flag raise the keypad request
// R5: level select zero makes a low level active
// R6: level select one makes a high level active
// R7: all eight line sources merge into one shared-vector request
// R8: merged request is gated by the global keypad enable bit
// R9: software writes to the flag register are ignored
// R10: an active level on the port wakes the core from idle and power-down; the code raises keypad_wakeup only for lines whose enable bit is one
// R11: a line active during the clearing read keeps its flag set
package kli_pkg;
  localparam int unsigned KLI_LINES = 8;
  localparam logic [7:0] KLI_ADDR_LEVEL_SELECT = 8'h9C;
  localparam logic [7:0] KLI_ADDR_LINE_ENABLE  = 8'h9D;
  localparam logic [7:0] KLI_ADDR_LINE_FLAGS   = 8'h9E;
  localparam logic [7:0] KLI_RST_LEVEL_SELECT  = 8'h00;
  localparam logic [7:0] KLI_RST_LINE_ENABLE   = 8'h00;
  localparam logic [7:0] KLI_RST_LINE_FLAGS    = 8'h00;
  localparam logic [7:0] KLI_RST_RDATA         = 8'h00;
endpackage

//--- hw/kli_line_detect.sv
// per-line active level detection and flag storage
`timescale 1ns/100ps
module kli_line_detect (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // line inputs
  input  wire logic       pin_level,
  input  wire logic       level_select,
  input  wire logic       clear_flag,
  // state
  output logic            active,
  output logic            flag
);
  import kli_pkg::*;

  wire logic hit;
  wire logic next_flag;

  // xnor picks the level: low when select is 0, high when 1
  assign hit       = ~(pin_level ^ level_select);         // R5 R6
  // set wins over the read-clear
  assign next_flag = hit | (flag & ~clear_flag);          // R1 R2 R11

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag   <= 1'b0;
      active <= 1'b0;
    end else begin
      flag   <= next_flag;
      active <= hit;
    end
  end
endmodule

//--- hw/kli_top.sv
// keypad level interrupt block: registers, detection and request merge
`timescale 1ns/100ps
module kli_top (
  // clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          rst_n,
  // special function register port
  input  wire logic [7:0]                    sfr_addr,
  input  wire logic [7:0]                    sfr_wdata,
  input  wire logic                          sfr_wr,
  input  wire logic                          sfr_rd,
  output logic      [7:0]                    sfr_rdata,
  // keypad port and global enable
  input  wire logic [kli_pkg::KLI_LINES-1:0] keypad_port,
  input  wire logic                          keypad_global_irq_enable,
  // requests to the core
  output logic                               keypad_irq,
  output logic                               keypad_wakeup,
  output logic      [kli_pkg::KLI_LINES-1:0] keypad_line_is_key
);
  import kli_pkg::*;

  // one address compare, shared by the read mux and the write strobes
  function automatic logic kli_addr_hit(input logic [7:0] addr,
                                        input logic [7:0] reg_addr);
    return addr == reg_addr;
  endfunction

  // programmed registers, built bit by bit below
  wire logic [KLI_LINES-1:0] key_level_select;
  wire logic [KLI_LINES-1:0] key_line_enable;
  // per-line detection state from the line slices
  wire logic [KLI_LINES-1:0] key_line_flags;
  wire logic [KLI_LINES-1:0] line_active;

  // address decode and qualified strobes
  wire logic                 sel_level;
  wire logic                 sel_enable;
  wire logic                 sel_flags;
  wire logic                 sel_none;
  wire logic                 wr_level;
  wire logic                 wr_enable;
  wire logic                 flags_read;

  // read path
  wire logic [7:0]           rd_term_level;
  wire logic [7:0]           rd_term_enable;
  wire logic [7:0]           rd_term_flags;
  wire logic [7:0]           next_rdata;

  // request merge
  wire logic [KLI_LINES-1:0] flags_masked;
  wire logic [KLI_LINES-1:0] active_masked;
  wire logic                 any_flag_masked;
  wire logic                 any_active_masked;
  wire logic                 next_irq;
  wire logic                 next_wakeup;
  wire logic [KLI_LINES-1:0] next_line_is_key;

  assign sel_level  = kli_addr_hit(sfr_addr, KLI_ADDR_LEVEL_SELECT);
  assign sel_enable = kli_addr_hit(sfr_addr, KLI_ADDR_LINE_ENABLE);
  assign sel_flags  = kli_addr_hit(sfr_addr, KLI_ADDR_LINE_FLAGS);
  assign sel_none   = ~(sel_level | sel_enable | sel_flags);

  // no write strobe exists for the flag address, so flag writes cannot land
  assign wr_level   = sfr_wr & sel_level;                 // R9
  assign wr_enable  = sfr_wr & sel_enable;                // R9
  assign flags_read = sfr_rd & sel_flags;                 // R2

  assign rd_term_level  = sel_level  ? key_level_select : KLI_RST_RDATA;
  assign rd_term_enable = sel_enable ? key_line_enable  : KLI_RST_RDATA;
  assign rd_term_flags  = sel_flags  ? key_line_flags   : KLI_RST_RDATA;
  // unmapped addresses read as zero
  assign next_rdata     = sel_none ? KLI_RST_RDATA :
                          (rd_term_level | rd_term_enable | rd_term_flags);

  assign flags_masked      = key_line_flags & key_line_enable;       // R3 R4
  assign any_flag_masked   = |flags_masked;                          // R7
  assign next_irq          = keypad_global_irq_enable & any_flag_masked; // R8
  // wake ignores the global enable: the core may sleep with it cleared
  assign active_masked     = line_active & key_line_enable;
  assign any_active_masked = |active_masked;
  assign next_wakeup       = any_active_masked;                      // R10
  assign next_line_is_key  = key_line_enable;                        // R3

  genvar b;
  generate
    for (b = 0; b < KLI_LINES; b++) begin : g_cfg
      logic level_bit;
      logic enable_bit;

      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          level_bit <= KLI_RST_LEVEL_SELECT[b];
        end else if (wr_level) begin
          level_bit <= sfr_wdata[b];                      // R5 R6
        end
      end

      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          enable_bit <= KLI_RST_LINE_ENABLE[b];
        end else if (wr_enable) begin
          enable_bit <= sfr_wdata[b];                     // R3 R4
        end
      end

      assign key_level_select[b] = level_bit;
      assign key_line_enable[b]  = enable_bit;
    end
  endgenerate

  genvar g;
  generate
    for (g = 0; g < KLI_LINES; g++) begin : g_line
      kli_line_detect u_det (
        .sys_clk      (sys_clk),
        .rst_n        (rst_n),
        .pin_level    (keypad_port[g]),
        .level_select (key_level_select[g]),
        .clear_flag   (flags_read),
        .active       (line_active[g]),
        .flag         (key_line_flags[g])
      );
    end
  endgenerate

  // read data shows the pre-clear flags, taken on the clearing edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= KLI_RST_RDATA;
    end else begin
      sfr_rdata <= next_rdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      keypad_irq <= 1'b0;
    end else begin
      keypad_irq <= next_irq;                             // R7 R8
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      keypad_wakeup <= 1'b0;
    end else begin
      keypad_wakeup <= next_wakeup;                       // R10
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      keypad_line_is_key <= KLI_RST_LINE_ENABLE;
    end else begin
      keypad_line_is_key <= next_line_is_key;             // R3
    end
  end
endmodule

//--- verif/kli_keys.sv
// keypad model: port lines idle high, a pressed key pulls its line low
`timescale 1ns/100ps
module kli_keys (
  // key state and port
  input  wire logic [7:0] press,
  output logic      [7:0] port
);
  assign port = ~press;
endmodule

//--- verif/kli_checker.sv
// port assertions for the keypad level interrupt block
`timescale 1ns/100ps
module kli_checker (
  // watched ports of the top module
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic       keypad_global_irq_enable,
  input wire logic       keypad_irq,
  input wire logic       keypad_wakeup,
  input wire logic [7:0] keypad_line_is_key
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_global_gate: assert property (!keypad_global_irq_enable |=> !keypad_irq)
    else $error("irq without global enable");
  a_irq_rise: assert property ($rose(keypad_irq) |-> $past(keypad_global_irq_enable))
    else $error("irq rose while gated");
  a_irq_lines: assert property (keypad_irq |-> keypad_line_is_key != 8'h00)
    else $error("irq with no enabled line");
  a_wake_lines: assert property (keypad_wakeup |-> keypad_line_is_key != 8'h00)
    else $error("wakeup with no enabled line");
  a_irq_hold: assert property (keypad_irq && keypad_global_irq_enable && !$past(sfr_rd)
    && !$past(sfr_wr) |=> keypad_irq) else $error("irq dropped without read");
  a_reg_readback: assert property (sfr_wr && sfr_addr inside {8'h9C, 8'h9D} ##1
    sfr_addr == $past(sfr_addr) |=> sfr_rdata == $past(sfr_wdata, 2)) else $error("readback");
  a_key_copy: assert property (sfr_wr && sfr_addr == 8'h9D |=>
    ##1 keypad_line_is_key == $past(sfr_wdata, 2)) else $error("line enable copy");
  a_unmapped_zero: assert property (!(sfr_addr inside {8'h9C, 8'h9D, 8'h9E}) |=>
    sfr_rdata == 8'h00) else $error("unmapped read not zero");
endmodule

//--- verif/keypad_level_interrupt_bench.sv
// self-checking bench for the keypad level interrupt block
`timescale 1ns/100ps
module keypad_level_interrupt_bench;
  import kli_pkg::*;
  logic       sys_clk = 0, rst_n = 0, sfr_wr = 0, sfr_rd = 0, glb = 0, irq, wake;
  logic [7:0] sfr_addr = 0, sfr_wdata = 0, press = 0, port, rdata, is_key;
  int         miscompares = 0, checks = 0;
  always #5 sys_clk = ~sys_clk;
  kli_keys u_keys (.press(press), .port(port));
  kli_top u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(rdata),
    .keypad_port(port), .keypad_global_irq_enable(glb), .keypad_irq(irq),
    .keypad_wakeup(wake), .keypad_line_is_key(is_key));
  task automatic chk(input logic [7:0] got, exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: %h not %h", $time, got, exp);
    end
  endtask
  // one-cycle strobe, address held so read data is taken before it moves on
  task automatic acc(input logic [7:0] a, d, input logic w);
    @(negedge sys_clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = w;
    sfr_rd = !w;
    @(negedge sys_clk);
    sfr_wr = 0;
    sfr_rd = 0;
  endtask
  task automatic rd(input logic [7:0] a, exp);
    acc(a, 8'h00, 0);
    chk(rdata, exp);
  endtask
  task automatic t_regs;
    acc(8'h9E, 8'hFF, 1);
    rd(8'h9E, 8'h00);
    acc(8'h9C, 8'hA5, 1);
    acc(8'h9D, 8'h01, 1);
    rd(8'h9F, 8'h00);
    rd(8'h9C, 8'hA5);
    chk(is_key, 8'h01);
    chk(irq, 8'h00);
    rd(8'h9E, 8'hA5);
    acc(8'h9C, 8'h00, 1);
    rd(8'h9E, 8'hA5);
    rd(8'h9E, 8'h00);
    $display("t_regs done");
  endtask
  task automatic t_low;
    glb = 1;
    press = 8'h02;
    repeat (3) @(negedge sys_clk);
    chk(irq, 8'h00);
    press = 8'h03;
    repeat (3) @(negedge sys_clk);
    chk(irq, 8'h01);
    chk(wake, 8'h01);
    press = 8'h00;
    rd(8'h9E, 8'h03);
    repeat (2) @(negedge sys_clk);
    chk(irq, 8'h00);
    chk(wake, 8'h00);
    press = 8'h04;
    rd(8'h9E, 8'h04);
    press = 8'h00;
    rd(8'h9E, 8'h04);
    rd(8'h9E, 8'h00);
    $display("t_low done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge sys_clk);
    rst_n = 1;
    t_regs;
    t_low;
    tally_and_finish;
  end
  initial begin
    #5000;
    miscompares++;
    tally_and_finish;
  end
endmodule
bind kli_top kli_checker u_chk (
  .sys_clk                  (sys_clk),
  .rst_n                    (rst_n),
  .sfr_addr                 (sfr_addr),
  .sfr_wdata                (sfr_wdata),
  .sfr_wr                   (sfr_wr),
  .sfr_rd                   (sfr_rd),
  .sfr_rdata                (sfr_rdata),
  .keypad_global_irq_enable (keypad_global_irq_enable),
  .keypad_irq               (keypad_irq),
  .keypad_wakeup            (keypad_wakeup),
  .keypad_line_is_key       (keypad_line_is_key)
);
